// ### common/gsr_pkg.sv
package gsr_pkg;
  // serial poll byte bit positions
  localparam int ST_OVFL = 0;
  localparam int ST_FULL = 1;
  localparam int ST_HALF = 2;
  localparam int ST_DONE = 3;
  localparam int ST_READY = 4;
  localparam int ST_ERROR = 5;
  localparam int ST_RQS = 6;
  localparam int ST_UNUSED = 7;
  localparam int ERR_COUNT = 13;
  // mask value after reset and device clear; status value after reset only
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // typical hold-off figures and the cycle counts derived from them
  localparam int CLK_HZ = 50_000_000;
  localparam int MASK_HOLD_MS = 57;
  localparam int CAL_HOLD_MS = 8850;
  localparam int MASK_HOLD_CYC = MASK_HOLD_MS * (CLK_HZ / 1000);
  localparam int CAL_HOLD_CYC = CAL_HOLD_MS * (CLK_HZ / 1000);
  localparam int HOLD_CNT_W = 32;

  // end and hold-off settings, in their numeric order 0..3
  typedef enum logic [1:0] {
    EOI_ON_HOLDOFF_ON,
    EOI_OFF_HOLDOFF_ON,
    EOI_ON_HOLDOFF_OFF,
    EOI_OFF_HOLDOFF_OFF
  } gsr_mode_t;
  localparam gsr_mode_t MODE_RST = EOI_ON_HOLDOFF_ON;

  typedef enum logic {
    HOLD_IDLE,
    HOLD_BUSY
  } gsr_hold_st_t;

  // instrument conditions feeding the status byte
  typedef struct packed {
    logic overrange;
    logic store_full;
    logic store_half;
    logic store_enable;
    logic conv_done;
    logic reading_busy;
    logic cmd_busy;
  } gsr_cond_t;

  // listener events that may start a hold-off
  typedef struct packed {
    logic exec_char;
    logic eoi_rx;
    logic term_rx;
  } gsr_hold_ev_t;
endpackage

// ### core/gsr_srq_holdoff.sv
// Contract
// - masked conditions raise a service request
// - mask weights 1,2,4,8,16,32 per condition
// - mask value zero disables all requests
// - power-up and device clear clear mask
// - bit 0 follows over-range input
// - bit 1 set full, cleared on re-enable
// - bit 2 set half full, cleared re-enable
// - bit 3 conversion done, clear while processing
// - bit 4 ready, clear while commands process
// - bit 5 sticky error until error query
// - bit 6 shows request, cleared by poll
// - bit 7 always reads zero
// - status latched at request, poll releases line
// - illegal option sets error, may request service
// - four end and hold-off settings
// - EOI with final byte when enabled
// - clear returns mode to setting 0
// - hold NRFD after execute until processed
// - hold-off also on EOI or terminator
// - hold-off length depends on command
// - error query clears errors, re-enables requests
module gsr_srq_holdoff #(
  parameter int MASK_HOLD_CYCLES = gsr_pkg::MASK_HOLD_CYC,
  parameter int CAL_HOLD_CYCLES = gsr_pkg::CAL_HOLD_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic dev_clear_i,
  input wire logic mask_wr_i,
  input wire logic [7:0] mask_data_i,
  input wire logic mode_wr_i,
  input wire gsr_pkg::gsr_mode_t mode_data_i,
  input wire logic cal_cmd_i,
  input wire gsr_pkg::gsr_cond_t cond_i,
  input wire logic [gsr_pkg::ERR_COUNT-1:0] err_evt_i,
  input wire logic illegal_option_error_i,
  input wire logic error_word_query_i,
  input wire logic spoll_rd_i,
  input wire gsr_pkg::gsr_hold_ev_t hold_ev_i,
  input wire logic talk_byte_i,
  input wire logic last_byte_i,
  output logic srq_o,
  output logic [7:0] spoll_byte_o,
  output logic [7:0] live_status_o,
  output logic eoi_o,
  output logic nrfd_hold_o,
  output gsr_pkg::gsr_mode_t mode_o
);
  import gsr_pkg::*;

  logic [7:0] mask_q;
  gsr_mode_t mode_q;
  logic [5:0] stat_q;
  logic [5:0] stat_prev_q;
  logic rqs_q;
  logic err_block_q;
  logic [7:0] latch_q;
  logic eoi_q;
  gsr_hold_st_t hold_q;
  logic [HOLD_CNT_W-1:0] hold_cnt_q;
  logic [5:0] rise;
  logic req_fire;
  logic err_set;
  logic hold_trig;
  logic [7:0] live;

  // a zero minimum would let nrfd drop before the count could run
  if (MASK_HOLD_CYCLES < 1 || CAL_HOLD_CYCLES < 1)
  begin : gen_hold_chk
    $error("hold cycle counts must be at least one");
  end

  // mask register; clear wins because it comes from the bus itself
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mask_q <= MASK_RST;
    else if (ce_i)
    begin
      if (dev_clear_i)
        mask_q <= MASK_RST;
      else if (mask_wr_i)
        mask_q <= {2'b00, mask_data_i[5:0]};
    end
  end

  // end and hold-off setting
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mode_q <= MODE_RST;
    else if (ce_i)
    begin
      if (dev_clear_i)
        mode_q <= MODE_RST;
      else if (mode_wr_i)
        mode_q <= mode_data_i;
    end
  end

  assign err_set = (|err_evt_i) | illegal_option_error_i;

  // live status bits; every set beats its clear in the same cycle
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      stat_q <= STATUS_RST[5:0];
    else if (ce_i)
    begin
      stat_q[ST_OVFL] <= cond_i.overrange;
      if (cond_i.store_full)
        stat_q[ST_FULL] <= 1'b1;
      else if (cond_i.store_enable)
        stat_q[ST_FULL] <= 1'b0;
      if (cond_i.store_half)
        stat_q[ST_HALF] <= 1'b1;
      else if (cond_i.store_enable)
        stat_q[ST_HALF] <= 1'b0;
      if (cond_i.conv_done)
        stat_q[ST_DONE] <= 1'b1;
      else if (cond_i.reading_busy)
        stat_q[ST_DONE] <= 1'b0;
      stat_q[ST_READY] <= !cond_i.cmd_busy && hold_q == HOLD_IDLE;
      if (err_set)
        stat_q[ST_ERROR] <= 1'b1;
      else if (error_word_query_i)
        stat_q[ST_ERROR] <= 1'b0;
    end
  end

  // request on a masked bit newly going true; errors wait for the query
  assign rise = stat_q & ~stat_prev_q & mask_q[5:0];
  assign req_fire = !rqs_q && !dev_clear_i
    && (|rise[ST_READY:ST_OVFL] || (rise[ST_ERROR] && !err_block_q));
  assign live = {1'b0, rqs_q, stat_q};

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      stat_prev_q <= STATUS_RST[5:0];
    else if (ce_i)
      stat_prev_q <= stat_q;
  end

  // request line and its latched byte; the poll releases them
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rqs_q <= 1'b0;
      latch_q <= STATUS_RST;
    end
    else if (ce_i)
    begin
      if (req_fire)
      begin
        rqs_q <= 1'b1;
        latch_q <= {1'b0, 1'b1, stat_q};
      end
      else if (spoll_rd_i || dev_clear_i)
        rqs_q <= 1'b0;
    end
  end

  // one error request per query, so a burst of errors cannot re-request
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      err_block_q <= 1'b0;
    else if (ce_i)
    begin
      if (req_fire && rise[ST_ERROR])
        err_block_q <= 1'b1;
      else if (error_word_query_i || dev_clear_i)
        err_block_q <= 1'b0;
    end
  end

  // eoi travels with the final byte of a talk transfer
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      eoi_q <= 1'b0;
    else if (ce_i)
      eoi_q <= talk_byte_i && last_byte_i
        && (mode_q == EOI_ON_HOLDOFF_ON || mode_q == EOI_ON_HOLDOFF_OFF);
  end

  assign hold_trig = (mode_q == EOI_ON_HOLDOFF_ON || mode_q == EOI_OFF_HOLDOFF_ON)
    && (hold_ev_i.exec_char || hold_ev_i.eoi_rx || hold_ev_i.term_rx);

  // hold-off: the triggering byte is already handshaken, nrfd then stays
  // low until processing ends and the per-command minimum has run out
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hold_q <= HOLD_IDLE;
      hold_cnt_q <= '0;
    end
    else if (ce_i)
    begin
      case (hold_q)
        HOLD_IDLE:
        begin
          hold_cnt_q <= '0;
          if (hold_trig && !dev_clear_i)
            hold_q <= HOLD_BUSY;
        end
        HOLD_BUSY:
        begin
          if (dev_clear_i)
            hold_q <= HOLD_IDLE;
          else if (cal_cmd_i)
            hold_cnt_q <= HOLD_CNT_W'(CAL_HOLD_CYCLES);
          else if (mask_wr_i)
            hold_cnt_q <= HOLD_CNT_W'(MASK_HOLD_CYCLES);
          else if (hold_cnt_q != '0)
            hold_cnt_q <= hold_cnt_q - 1'b1;
          else if (!cond_i.cmd_busy && !hold_trig)
            hold_q <= HOLD_IDLE;
        end
        default:
          hold_q <= HOLD_IDLE;
      endcase
    end
  end

  // outputs straight from flops
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      srq_o <= 1'b0;
      spoll_byte_o <= STATUS_RST;
      live_status_o <= STATUS_RST;
      eoi_o <= 1'b0;
      nrfd_hold_o <= 1'b0;
      mode_o <= MODE_RST;
    end
    else if (ce_i)
    begin
      srq_o <= rqs_q;
      spoll_byte_o <= rqs_q ? latch_q : live;
      live_status_o <= live;
      eoi_o <= eoi_q;
      nrfd_hold_o <= hold_q == HOLD_BUSY;
      mode_o <= mode_q;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  mask_zero_quiet_a: assert property (ce_i && mask_q == 8'h00 && !rqs_q |=> !rqs_q)
    else $error("request raised with empty mask");
  clear_mask_a: assert property (ce_i && dev_clear_i |=> mask_q == 8'h00 && mode_q == MODE_RST)
    else $error("device clear left mask or mode set");
  bit7_zero_a: assert property (!spoll_byte_o[ST_UNUSED] && !live_status_o[ST_UNUSED])
    else $error("unused status bit set");
  err_sticky_a: assert property (ce_i && err_set |=> stat_q[ST_ERROR])
    else $error("error event not recorded");
  err_query_a: assert property (ce_i && error_word_query_i && !err_set |=> !stat_q[ST_ERROR])
    else $error("error bit survived the query");
  srq_hold_a: assert property (ce_i && rqs_q && !spoll_rd_i && !dev_clear_i |=> rqs_q)
    else $error("request dropped before poll");
  latch_byte_a: assert property (ce_i && req_fire ##1 ce_i |=> spoll_byte_o == latch_q)
    else $error("poll byte not latched at request");
  poll_release_a: assert property (ce_i && spoll_rd_i && !req_fire |=> !rqs_q)
    else $error("poll did not release request");
  eoi_mode_a: assert property (eoi_o |-> $past(mode_q, 2) inside {EOI_ON_HOLDOFF_ON,
    EOI_ON_HOLDOFF_OFF})
    else $error("eoi sent while suppressed");
  hold_start_a: assert property (ce_i && hold_trig && hold_q == HOLD_IDLE && !dev_clear_i
    |=> hold_q == HOLD_BUSY)
    else $error("hold-off not started");
  hold_mode_a: assert property (hold_q == HOLD_IDLE && mode_q inside {EOI_ON_HOLDOFF_OFF,
    EOI_OFF_HOLDOFF_OFF} |=> hold_q == HOLD_IDLE)
    else $error("hold-off in a no-hold setting");
  hold_min_a: assert property (ce_i && hold_q == HOLD_BUSY && hold_cnt_q != '0
    |=> hold_q == HOLD_BUSY || $past(dev_clear_i))
    else $error("hold-off ended before its minimum");
  // status bits against their set and clear conditions
  ovfl_follow_a: assert property (ce_i
    |=> stat_q[ST_OVFL] == $past(cond_i.overrange))
    else $error("overrange bit not following input");
  ready_busy_a: assert property (ce_i && cond_i.cmd_busy |=> !stat_q[ST_READY])
    else $error("ready bit set while commands process");
  store_clear_a: assert property (ce_i && cond_i.store_enable
    && !cond_i.store_full |=> !stat_q[ST_FULL])
    else $error("full bit survived store re-enable");
  done_clear_a: assert property (ce_i && cond_i.reading_busy
    && !cond_i.conv_done |=> !stat_q[ST_DONE])
    else $error("done bit set while a reading is processed");

  error_srq_c: cover property (err_set ##[1:4] srq_o ##[1:20] spoll_rd_i);
  hold_cycle_c: cover property (hold_q == HOLD_IDLE ##1 hold_q == HOLD_BUSY ##[1:50]
    hold_q == HOLD_IDLE);
  eoi_sent_c: cover property (eoi_o);
  done_srq_c: cover property (rise[ST_DONE] && req_fire);
  hold_min_c: cover property (hold_q == HOLD_BUSY && hold_cnt_q != '0 ##1 hold_cnt_q == '0);
endmodule

// ### sim/gsr_bus_ctrl.sv
module gsr_bus_ctrl (
  input wire logic mclk_i,
  input wire logic srq_i,
  input wire logic [7:0] spoll_byte_i,
  input wire logic slow_i,
  output logic spoll_rd_o,
  output logic [7:0] polled_o,
  output logic [7:0] polls_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_n = 0;
  // quiet bus at start
  initial
  begin
    spoll_rd_o = 1'b0;
    polled_o = 8'h00;
    polls_o = 8'h00;
  end
  // poll once srq has stood a while; pause outlasts the srq drop after a poll
  always @(negedge mclk_i)
  begin
    spoll_rd_o <= 1'b0;
    wait_n <= srq_i ? wait_n + 1 : 0;
    if (srq_i && wait_n >= (slow_i ? 9 : 3))
    begin
      spoll_rd_o <= 1'b1;
      polled_o <= spoll_byte_i;
      polls_o <= polls_o + 8'h01;
      wait_n <= 0;
    end
  end
endmodule

// ### sim/tb_gsr_srq_holdoff.sv
module tb_gsr_srq_holdoff;
  timeunit 1ns;
  timeprecision 1ns;
  import gsr_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic dclr = 1'b0;
  logic mwr = 1'b0;
  logic owr = 1'b0;
  logic opt = 1'b0;
  logic qry = 1'b0;
  logic talk = 1'b0;
  logic slow = 1'b0;
  logic ce = 1'b1;
  logic cal = 1'b0;
  logic [7:0] mdat = 8'h00;
  logic [12:0] err = 13'h0000;
  gsr_mode_t md = EOI_ON_HOLDOFF_ON;
  gsr_cond_t cnd = '0;
  gsr_hold_ev_t hev = '0;
  logic spr, srq, eoi, nrfd;
  logic [7:0] spb, live, pol, npol, n0, want;
  logic [3:0] k;
  gsr_mode_t mo;
  int fails = 0;
  int checks_done = 0;
  // mask in 15:8, event kind in 7:4, request expected in bit 0
  logic [15:0] rows [11] = '{16'h0101, 16'h0211, 16'h0421, 16'h0831, 16'h1041,
    16'h2051, 16'h0000, 16'h0050, 16'h0311, 16'hFE00, 16'hC831};

  always #10 mclk_i = ~mclk_i;

  // short hold minimum so the run stays brief
  gsr_srq_holdoff #(.MASK_HOLD_CYCLES(20), .CAL_HOLD_CYCLES(50)) gsr_srq_holdoff_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce), .dev_clear_i(dclr),
    .mask_wr_i(mwr), .mask_data_i(mdat), .mode_wr_i(owr), .mode_data_i(md),
    .cal_cmd_i(cal), .cond_i(cnd), .err_evt_i(err), .illegal_option_error_i(opt),
    .error_word_query_i(qry), .spoll_rd_i(spr), .hold_ev_i(hev), .talk_byte_i(talk),
    .last_byte_i(talk), .srq_o(srq), .spoll_byte_o(spb), .live_status_o(live),
    .eoi_o(eoi), .nrfd_hold_o(nrfd), .mode_o(mo));

  gsr_bus_ctrl gsr_bus_ctrl_i (.mclk_i(mclk_i), .srq_i(srq), .spoll_byte_i(spb),
    .slow_i(slow), .spoll_rd_o(spr), .polled_o(pol), .polls_o(npol));

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  task automatic end_sim;
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wmask(input logic [7:0] v);
    mdat = v;
    mwr = 1'b1;
    cyc(1);
    mwr = 1'b0;
  endtask

  // held three cycles so a level condition is latched before it drops
  task automatic hit(input logic [3:0] kind);
    case (kind)
      4'h0: cnd.overrange = 1'b1;
      4'h1: cnd.store_full = 1'b1;
      4'h2: cnd.store_half = 1'b1;
      4'h3: cnd.conv_done = 1'b1;
      4'h4: cnd.cmd_busy = 1'b1;
      default: err[0] = 1'b1;
    endcase
    cyc(3);
    cnd = '0;
    err = 13'h0000;
  endtask

  // clear sticky bits between rows so every row starts with those bits low
  task automatic clr;
    cnd.store_enable = 1'b1;
    cnd.reading_busy = 1'b1;
    qry = 1'b1;
    dclr = 1'b1;
    cyc(1);
    cnd = '0;
    qry = 1'b0;
    dclr = 1'b0;
    cyc(2);
  endtask

  task automatic expect_polls(input string nm, input logic [3:0] kind, input logic e);
    n0 = npol;
    hit(kind);
    cyc(16);
    chk(nm, npol - n0, {7'h00, e});
  endtask

  // main sequence
  initial
  begin
    cyc(20);
    chk("reset out", {srq, eoi, nrfd, mo, 3'h0}, 8'h00);
    chk("reset byte", spb, 8'h00);
    rst_n_i = 1'b1;
    cyc(1);
    for (int i = 0; i < 11; i++)
    begin
      clr();
      chk("cleared", live & 8'h2F, 8'h00);
      wmask(rows[i][15:8]);
      slow = i[0];
      k = rows[i][7:4];
      expect_polls("polls", k, rows[i][0]);
      // over-range follows its input, store and done bits stay until cleared
      want = (k inside {4'h1, 4'h2, 4'h3}) ? (8'h01 << k) : 8'h00;
      chk("live", live & 8'h1F, want | 8'h10);
      if (rows[i][0])
        chk("byte", pol & ((8'h01 << k) | 8'hC0), (8'h01 << k) | 8'h40);
      chk("after poll", {spb[7:6], 5'h00, srq}, 8'h00);
    end
    wmask(8'h00);
    for (int m = 0; m < 4; m++)
    begin
      md = gsr_mode_t'(m);
      owr = 1'b1;
      cyc(1);
      owr = 1'b0;
      cyc(1);
      chk("mode", {6'h00, mo}, m[7:0]);
      talk = 1'b1;
      cyc(1);
      talk = 1'b0;
      cyc(1);
      chk("eoi", {7'h00, eoi}, {7'h00, ~m[0]});
      cnd.cmd_busy = 1'b1;
      hev = 3'b100 >> (m % 3);
      cyc(1);
      hev = '0;
      cyc(30);
      chk("hold", {7'h00, nrfd}, {7'h00, ~m[1]});
      chk("busy", {7'h00, live[4]}, 8'h00);
      cnd.cmd_busy = 1'b0;
      cyc(60);
      chk("release", {7'h00, nrfd}, 8'h00);
    end
    wmask(8'h20);
    dclr = 1'b1;
    cyc(1);
    dclr = 1'b0;
    cyc(1);
    chk("clear mode", {6'h00, mo}, 8'h00);
    expect_polls("clear mask", 4'h5, 1'b0);
    // minimum outlasts idle processing: mask write on execute, calibration on terminator
    mdat = 8'h00;
    for (int h = 0; h < 2; h++)
    begin
      hev.exec_char = (h == 0);
      hev.term_rx = (h == 1);
      cyc(1);
      hev = '0;
      mwr = (h == 0);
      cal = (h == 1);
      cyc(1);
      mwr = 1'b0;
      cal = 1'b0;
      cyc(10);
      chk("hold min", {7'h00, nrfd}, 8'h01);
      cyc(h == 0 ? 20 : 50);
      chk("hold end", {7'h00, nrfd}, 8'h00);
    end
    // a low enable freezes all state, strobes included
    ce = 1'b0;
    md = EOI_OFF_HOLDOFF_OFF;
    owr = 1'b1;
    cyc(1);
    owr = 1'b0;
    cyc(2);
    ce = 1'b1;
    cyc(2);
    chk("frozen mode", {6'h00, mo}, 8'h00);
    clr();
    wmask(8'h20);
    n0 = npol;
    opt = 1'b1;
    cyc(1);
    opt = 1'b0;
    cyc(16);
    chk("option err", npol - n0, 8'h01);
    expect_polls("second err", 4'h5, 1'b0);
    chk("err sticky", {7'h00, live[5]}, 8'h01);
    qry = 1'b1;
    cyc(1);
    qry = 1'b0;
    cyc(2);
    chk("err query", {7'h00, live[5]}, 8'h00);
    expect_polls("err again", 4'h5, 1'b1);
    end_sim();
  end

  // hang guard, well past the expected run length
  initial
  begin
    #100000;
    fails++;
    end_sim();
  end
endmodule
